//--- inc/dcc_pkg.sv
`default_nettype none
package dcc_pkg;
  // channel organisation
  localparam int DCC_CHANS = 8;
  localparam int DCC_GROUP = 4;
  localparam int DCC_WIDTH = 16;
  // clock and documented times
  localparam int DCC_CLK_NS = 4;
  localparam int DCC_CALC_NS = 600;
  localparam int DCC_TAIL_NS = 300;
  localparam int DCC_AB_NS = 600;
  localparam int DCC_SEQ_US = 300;
  // least times round up to whole cycles
  localparam int DCC_CALC_CYC = (DCC_CALC_NS + DCC_CLK_NS - 1) / DCC_CLK_NS;
  localparam int DCC_TAIL_CYC =
    (DCC_CALC_NS + DCC_TAIL_NS + DCC_CLK_NS - 1) / DCC_CLK_NS;
  localparam int DCC_AB_CYC = (DCC_AB_NS + DCC_CLK_NS - 1) / DCC_CLK_NS;
  localparam int DCC_SEQ_CYC =
    (DCC_SEQ_US * 1000 + DCC_CLK_NS - 1) / DCC_CLK_NS;
  // register defaults; default codes put every output on signal ground
  localparam logic [15:0] DCC_X_DEF = 16'h8000;
  localparam logic [15:0] DCC_M_DEF = 16'hffff;
  localparam logic [15:0] DCC_C_DEF = 16'h8000;
  localparam logic [15:0] DCC_DAC_DEF = 16'h8000;
  localparam logic [15:0] DCC_C_BIAS = 16'h8000;
  localparam logic [7:0] DCC_ABSEL_DEF = 8'h00;
  // write targets of the user-side register port
  typedef enum logic [2:0] {
    DCC_TGT_IN_A,
    DCC_TGT_IN_B,
    DCC_TGT_GAIN,
    DCC_TGT_OFFS,
    DCC_TGT_ABSEL
  } dcc_target_t;
  typedef enum logic {
    DCC_IDLE,
    DCC_CALC
  } dcc_state_t;
  // index of the lowest set bit, 0 when none
  function automatic logic [2:0] dcc_first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = DCC_CHANS - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : dcc_first_set
endpackage : dcc_pkg
`default_nettype wire

//--- hdl/dcc_edge.sv
`default_nettype none
module dcc_edge
  import dcc_pkg::*;
#(
  parameter bit RISE = 1'b1,
  parameter bit INIT = 1'b1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic pulse
);
  logic d_r;
  // previous level, parked at the idle level so reset makes no edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      d_r <= INIT;
    end
    else
    begin
      d_r <= d;
    end
  end
  assign pulse = RISE ? (d & ~d_r) : (~d & d_r);
endmodule : dcc_edge
`default_nettype wire

//--- hdl/dcc_calc.sv
`default_nettype none
module dcc_calc
  import dcc_pkg::*;
#(
  parameter int W = DCC_WIDTH,
  parameter int LAT = DCC_CALC_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [W-1:0] x,
  input wire logic [W-1:0] m,
  input wire logic [W-1:0] c,
  output logic done,
  output logic [W-1:0] result
);
  localparam int CW = $clog2(LAT + 1);
  logic [2*W:0] prod;
  logic signed [W+2:0] sum;
  logic [CW-1:0] cnt_r;
  // code = x*(m+1)/2^W + c - bias, clamped to the converter range
  always_comb
  begin
    prod = (2*W+1)'(x) * ((2*W+1)'(m) + (2*W+1)'(1));
    sum = $signed({2'b00, prod[2*W:W]}) + $signed({3'b000, c})
      - $signed({3'b000, DCC_C_BIAS});
  end
  // one shared engine: result held, done after the fixed latency
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      result <= DCC_DAC_DEF;
    end
    else if (start)
    begin
      cnt_r <= CW'(LAT);
      // sign bit set means the code fell below zero
      if (sum[W+2])
        result <= '0;
      else if (sum > $signed({3'b000, {W{1'b1}}}))
        result <= '1;
      else
        result <= sum[W-1:0];
    end
    else if (cnt_r != '0)
    begin
      cnt_r <= cnt_r - CW'(1);
    end
  end
  assign done = (cnt_r == CW'(1));
endmodule : dcc_calc
`default_nettype wire

//--- hdl/dcc_top.sv
`default_nettype none
module dcc_top
  import dcc_pkg::*;
#(
  parameter int W = DCC_WIDTH,
  parameter int SEQ_CYC = DCC_SEQ_CYC
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic device_reset_n,
  input wire logic output_clear_n,
  input wire logic load_outputs_n,
  input wire logic busy_in,
  input wire logic wr_en,
  input wire logic [2:0] wr_target,
  input wire logic [7:0] wr_chan_mask,
  input wire logic wr_ab,
  input wire logic [W-1:0] wr_data,
  output logic busy_out_r,
  output logic busy_oe_n_r,
  output logic seq_active_r,
  output logic out_to_ground_r,
  output logic [DCC_CHANS*W-1:0] dac_codes_r
);
  localparam int SW = $clog2(SEQ_CYC + 1);
  localparam int TW = $clog2(DCC_TAIL_CYC + 1);
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic dev_rise;
  logic load_fall;
  logic [SW-1:0] seq_cnt_r;
  logic [W-1:0] input_reg_a [DCC_CHANS];
  logic [W-1:0] input_reg_b [DCC_CHANS];
  logic [W-1:0] gain_r [DCC_CHANS];
  logic [W-1:0] offs_r [DCC_CHANS];
  logic [W-1:0] computed_reg_a [DCC_CHANS];
  logic [W-1:0] computed_reg_b [DCC_CHANS];
  logic [7:0] absel_r;
  logic [7:0] pend_a_r, pend_b_r, pend_a_nxt, pend_b_nxt;
  logic [7:0] set_a, set_b, clr_a, clr_b;
  logic [7:0] wrote_a_r, wrote_b_r;
  logic wr_ok;
  dcc_state_t state_r;
  logic [2:0] idx_r;
  logic side_r;
  logic calc_start, calc_done;
  logic [2:0] pick_idx;
  logic pick_side;
  logic [W-1:0] calc_result;
  logic [TW-1:0] tail_r;
  logic local_busy;
  logic line_free, line_free_d_r;
  logic load_req_r;
  logic fire;

  // release the system reset through two flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // edges of the device reset and load pins
  dcc_edge #(.RISE(1'b1), .INIT(1'b1)) u_dev_edge (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(device_reset_n),
    .pulse(dev_rise)
  );
  dcc_edge #(.RISE(1'b0), .INIT(1'b1)) u_load_edge (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(load_outputs_n),
    .pulse(load_fall)
  );

  // reset sequence timer, rising edge only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_cnt_r <= '0;
      seq_active_r <= 1'b0;
    end
    else if (dev_rise)
    begin
      seq_cnt_r <= SW'(SEQ_CYC);
      seq_active_r <= 1'b1;
    end
    else if (seq_cnt_r != '0)
    begin
      seq_cnt_r <= seq_cnt_r - SW'(1);
      seq_active_r <= (seq_cnt_r != SW'(1));
    end
  end

  // writes during the sequence are dropped; the host is told not to
  assign wr_ok = wr_en && !seq_active_r && !dev_rise;

  // decode which side each addressed channel recomputes
  always_comb
  begin
    set_a = 8'h00;
    set_b = 8'h00;
    case (wr_target)
      DCC_TGT_IN_A: set_a = wr_chan_mask;
      DCC_TGT_IN_B: set_b = wr_chan_mask;
      DCC_TGT_GAIN, DCC_TGT_OFFS:
      begin
        if (wr_ab)
          set_b = wr_chan_mask;
        else
          set_a = wr_chan_mask;
      end
      default:
      begin
        set_a = 8'h00;
        set_b = 8'h00;
      end
    endcase
    if (!wr_ok)
    begin
      set_a = 8'h00;
      set_b = 8'h00;
    end
  end

  // stored registers; clear never touches them
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DCC_CHANS; i++)
      begin
        input_reg_a[i] <= DCC_X_DEF;
        input_reg_b[i] <= DCC_X_DEF;
        gain_r[i] <= DCC_M_DEF;
        offs_r[i] <= DCC_C_DEF;
      end
      absel_r <= DCC_ABSEL_DEF;
    end
    else if (dev_rise)
    begin
      for (int i = 0; i < DCC_CHANS; i++)
      begin
        input_reg_a[i] <= DCC_X_DEF;
        input_reg_b[i] <= DCC_X_DEF;
        gain_r[i] <= DCC_M_DEF;
        offs_r[i] <= DCC_C_DEF;
      end
      absel_r <= DCC_ABSEL_DEF;
    end
    else if (wr_ok)
    begin
      for (int i = 0; i < DCC_CHANS; i++)
      begin
        if (wr_chan_mask[i])
        begin
          case (wr_target)
            DCC_TGT_IN_A: input_reg_a[i] <= wr_data;
            DCC_TGT_IN_B: input_reg_b[i] <= wr_data;
            DCC_TGT_GAIN: gain_r[i] <= wr_data;
            DCC_TGT_OFFS: offs_r[i] <= wr_data;
            DCC_TGT_ABSEL: absel_r[i] <= wr_data[i % DCC_GROUP];
            default: absel_r <= absel_r;
          endcase
        end
      end
    end
  end

  // engine picks the lowest pending channel, side A before B
  assign pick_side = (pend_a_r == 8'h00);
  assign pick_idx = pick_side ? dcc_first_set(pend_b_r)
                              : dcc_first_set(pend_a_r);
  assign calc_start = ((state_r == DCC_IDLE) || calc_done)
    && ((pend_a_r | pend_b_r) != 8'h00) && !dev_rise;

  // pending work; a new write wins over the pick that clears it
  always_comb
  begin
    clr_a = 8'h00;
    clr_b = 8'h00;
    if (calc_start)
    begin
      if (pick_side)
        clr_b[pick_idx] = 1'b1;
      else
        clr_a[pick_idx] = 1'b1;
    end
    pend_a_nxt = (pend_a_r & ~clr_a) | set_a;
    pend_b_nxt = (pend_b_r & ~clr_b) | set_b;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_a_r <= 8'h00;
      pend_b_r <= 8'h00;
    end
    else if (dev_rise)
    begin
      pend_a_r <= 8'h00;
      pend_b_r <= 8'h00;
    end
    else
    begin
      pend_a_r <= pend_a_nxt;
      pend_b_r <= pend_b_nxt;
    end
  end

  // single shared multiplier, one channel at a time
  dcc_calc #(.W(W), .LAT(DCC_CALC_CYC)) u_calc (
    .clk(ref_clk),
    .rst_n(rst_n),
    .start(calc_start),
    .x(pick_side ? input_reg_b[pick_idx] : input_reg_a[pick_idx]),
    .m(gain_r[pick_idx]),
    .c(offs_r[pick_idx]),
    .done(calc_done),
    .result(calc_result)
  );

  // engine state and channel in flight
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= DCC_IDLE;
      idx_r <= 3'h0;
      side_r <= 1'b0;
    end
    else if (dev_rise)
    begin
      state_r <= DCC_IDLE;
    end
    else
    begin
      case (state_r)
        DCC_IDLE:
        begin
          if (calc_start)
            state_r <= DCC_CALC;
        end
        DCC_CALC:
        begin
          if (calc_done && !calc_start)
            state_r <= DCC_IDLE;
        end
        default: state_r <= DCC_IDLE;
      endcase
      if (calc_start)
      begin
        idx_r <= pick_idx;
        side_r <= pick_side;
      end
    end
  end

  // result lands in computed A or B of the channel
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DCC_CHANS; i++)
      begin
        computed_reg_a[i] <= DCC_DAC_DEF;
        computed_reg_b[i] <= DCC_DAC_DEF;
      end
    end
    else if (dev_rise)
    begin
      for (int i = 0; i < DCC_CHANS; i++)
      begin
        computed_reg_a[i] <= DCC_DAC_DEF;
        computed_reg_b[i] <= DCC_DAC_DEF;
      end
    end
    else if (calc_done && state_r == DCC_CALC)
    begin
      if (side_r)
        computed_reg_b[idx_r] <= calc_result;
      else
        computed_reg_a[idx_r] <= calc_result;
    end
  end

  // busy tail after the last result or a select write
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      tail_r <= '0;
    else if (dev_rise)
      tail_r <= '0;
    else if (calc_done && state_r == DCC_CALC && !calc_start)
      tail_r <= TW'(DCC_TAIL_CYC);
    else if (wr_ok && wr_target == DCC_TGT_ABSEL
             && tail_r < TW'(DCC_AB_CYC))
      tail_r <= TW'(DCC_AB_CYC);
    else if (tail_r != '0)
      tail_r <= tail_r - TW'(1);
  end

  assign local_busy = ((pend_a_r | pend_b_r) != 8'h00)
    || (state_r == DCC_CALC) || (tail_r != '0);

  // open drain: only ever pull low, release when done
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_oe_n_r <= 1'b1;
      busy_out_r <= 1'b0;
    end
    else
    begin
      busy_oe_n_r <= !local_busy;
      busy_out_r <= 1'b0;
    end
  end

  // the shared line decides, so other devices also hold us off
  assign line_free = busy_in && busy_oe_n_r && !local_busy;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      line_free_d_r <= 1'b1;
    else
      line_free_d_r <= line_free;
  end

  // update now, on release, or never while clear
  assign fire = output_clear_n && line_free && !dev_rise
    && (load_req_r || load_fall || (!load_outputs_n && !line_free_d_r));

  // remember a load edge seen while busy
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      load_req_r <= 1'b0;
    else if (!output_clear_n || dev_rise)
      load_req_r <= 1'b0;
    else if (load_fall && !line_free)
      load_req_r <= 1'b1;
    else if (fire)
      load_req_r <= 1'b0;
  end

  // written-since-last-load flags; a new result wins over the clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrote_a_r <= 8'h00;
      wrote_b_r <= 8'h00;
    end
    else if (dev_rise)
    begin
      wrote_a_r <= 8'h00;
      wrote_b_r <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < DCC_CHANS; i++)
      begin
        if (calc_done && state_r == DCC_CALC && idx_r == 3'(i))
        begin
          if (side_r)
            wrote_b_r[i] <= 1'b1;
          else
            wrote_a_r[i] <= 1'b1;
        end
        else if (fire)
        begin
          wrote_a_r[i] <= 1'b0;
          wrote_b_r[i] <= 1'b0;
        end
      end
    end
  end

  // converter registers follow the selected source
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      dac_codes_r <= {DCC_CHANS{DCC_DAC_DEF}};
    else if (dev_rise)
      dac_codes_r <= {DCC_CHANS{DCC_DAC_DEF}};
    else if (fire)
    begin
      for (int i = 0; i < DCC_CHANS; i++)
      begin
        if (absel_r[i] && wrote_b_r[i])
          dac_codes_r[i*W +: W] <= computed_reg_b[i];
        else if (!absel_r[i] && wrote_a_r[i])
          dac_codes_r[i*W +: W] <= computed_reg_a[i];
      end
    end
  end

  // output buffers to ground while clear is low
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      out_to_ground_r <= 1'b1;
    else
      out_to_ground_r <= !output_clear_n;
  end

  sequence s_write_a;
    wr_ok && set_a != 8'h00;
  endsequence
  sequence s_busy_low;
    !busy_oe_n_r;
  endsequence

  property p_reset_defaults;
    @(posedge ref_clk) disable iff (!rst_n)
    dev_rise |=> seq_active_r && gain_r[0] == DCC_M_DEF
      && pend_a_r == 8'h00;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("reset edge did not restore defaults");

  property p_low_no_effect;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(device_reset_n) && !seq_active_r |=> !seq_active_r;
  endproperty
  a_low_no_effect: assert property (p_low_no_effect)
    else $error("falling device reset started a sequence");

  property p_clear_holds;
    @(posedge ref_clk) disable iff (!rst_n)
    !output_clear_n |=> out_to_ground_r && $stable(dac_codes_r);
  endproperty
  a_clear_holds: assert property (p_clear_holds)
    else $error("clear low did not ground or hold outputs");

  property p_write_busy;
    @(posedge ref_clk) disable iff (!rst_n)
    s_write_a |=> ##1 s_busy_low;
  endproperty
  a_write_busy: assert property (p_write_busy)
    else $error("write did not pull busy low");

  property p_no_update_busy;
    @(posedge ref_clk) disable iff (!rst_n)
    !busy_in && !dev_rise |=> $stable(dac_codes_r);
  endproperty
  a_no_update_busy: assert property (p_no_update_busy)
    else $error("outputs updated while busy line low");

  property p_stored_load;
    @(posedge ref_clk) disable iff (!rst_n)
    load_req_r && line_free && output_clear_n |-> fire ##1 !load_req_r;
  endproperty
  a_stored_load: assert property (p_stored_load)
    else $error("stored load not executed on release");

  property p_select_busy;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_ok && wr_target == DCC_TGT_ABSEL && !local_busy
      |-> ##2 s_busy_low [*8];
  endproperty
  a_select_busy: assert property (p_select_busy)
    else $error("select write did not hold busy low");

  property p_unwritten_keep;
    @(posedge ref_clk) disable iff (!rst_n)
    fire && !wrote_a_r[0] && !wrote_b_r[0]
      |=> $stable(dac_codes_r[W-1:0]);
  endproperty
  a_unwritten_keep: assert property (p_unwritten_keep)
    else $error("unwritten channel changed on load");

  property p_never_high;
    @(posedge ref_clk) disable iff (!rst_n)
    !busy_oe_n_r |-> !busy_out_r;
  endproperty
  a_never_high: assert property (p_never_high)
    else $error("busy driven high");
endmodule : dcc_top
`default_nettype wire

//--- tb/dcc_host_model.sv
`default_nettype none
module dcc_host_model
(
  input wire logic ref_clk,
  output logic device_reset_n,
  output logic output_clear_n,
  output logic load_outputs_n,
  output logic other_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // reset pin raised from the start
  initial
  begin
    device_reset_n = 1'b1;
    output_clear_n = 1'b1;
    load_outputs_n = 1'b1;
    other_busy_n = 1'b1;
  end
  // reset pin level, pulses held well over 30 ns
  task automatic set_reset(input logic v);
    @(posedge ref_clk);
    device_reset_n <= v;
  endtask : set_reset
  // clear level; the host holds it low around any span change
  task automatic set_clear(input logic v);
    @(posedge ref_clk);
    output_clear_n <= v;
  endtask : set_clear
  task automatic set_load(input logic v);
    @(posedge ref_clk);
    load_outputs_n <= v;
  endtask : set_load
  // another device on the shared busy wire, low means it is busy
  task automatic set_other(input logic v);
    @(posedge ref_clk);
    other_busy_n <= v;
  endtask : set_other
  // two cycles low so the falling edge is seen whatever the sync depth
  task automatic pulse_load();
    set_load(1'b0);
    @(posedge ref_clk);
    set_load(1'b1);
  endtask : pulse_load
endmodule : dcc_host_model
`default_nettype wire

//--- tb/test_dac_update_reset_clear_control.sv
`default_nettype none
module test_dac_update_reset_clear_control
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n;
  logic dev_rst_n, clr_n, ld_n, other_n, busy_in;
  logic wr_en;
  logic [2:0] wr_target;
  logic [7:0] wr_chan_mask;
  logic wr_ab;
  logic [15:0] wr_data;
  logic busy_out_r, busy_oe_n_r, seq_active_r, out_to_ground_r;
  logic [127:0] dac_codes_r, exp_c;
  int n_fail = 0;
  int checked = 0;
  int w;
  always #2 ref_clk = ~ref_clk;
  // shared busy wire: pull-up, our open-drain pin, another device
  assign busy_in = (busy_oe_n_r | busy_out_r) & other_n;
  dcc_host_model dcc_host_model_inst (.ref_clk(ref_clk),
    .device_reset_n(dev_rst_n), .output_clear_n(clr_n),
    .load_outputs_n(ld_n), .other_busy_n(other_n));
  dcc_top #(.SEQ_CYC(50)) dcc_top_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .device_reset_n(dev_rst_n),
    .output_clear_n(clr_n), .load_outputs_n(ld_n), .busy_in(busy_in),
    .wr_en(wr_en), .wr_target(wr_target), .wr_chan_mask(wr_chan_mask),
    .wr_ab(wr_ab), .wr_data(wr_data), .busy_out_r(busy_out_r),
    .busy_oe_n_r(busy_oe_n_r), .seq_active_r(seq_active_r),
    .out_to_ground_r(out_to_ground_r), .dac_codes_r(dac_codes_r));
  task automatic check(string nm, logic [127:0] seen, logic [127:0] ex);
    checked++;
    if (seen !== ex)
    begin
      $display("BAD %s exp %h seen %h", nm, ex, seen);
      n_fail++;
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic timeout();
    $display("BAD wait exp done seen timeout");
    n_fail++;
    give_verdict();
  endtask : timeout
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic write(logic [2:0] t, logic [7:0] m, logic ab,
                       logic [15:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    wr_target <= t;
    wr_chan_mask <= m;
    wr_ab <= ab;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : write
  // length in cycles of our own busy pull; bounded on both waits
  task automatic busy_len(output int n);
    int i;
    n = 0;
    for (i = 0; i < 10 && busy_oe_n_r !== 1'b0; i++)
      @(negedge ref_clk);
    if (i == 10)
      timeout();
    while (busy_oe_n_r === 1'b0)
    begin
      check("busy drive", busy_out_r, 1'b0);
      @(negedge ref_clk);
      n++;
      if (n > 5000)
        timeout();
    end
  endtask : busy_len
  // registering may stretch the pulse by a few cycles
  task automatic width_ok(int n, int ex);
    check("busy width", n >= ex - 1 && n <= ex + 3, 1'b1);
  endtask : width_ok
  task automatic t_defaults();
    exp_c = {8{DCC_DAC_DEF}};
    check("codes", dac_codes_r, exp_c);
    check("ground", out_to_ground_r, 1'b0);
    dcc_host_model_inst.pulse_load();
    cyc(4);
    check("codes", dac_codes_r, exp_c);
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_single();
    write(DCC_TGT_IN_A, 8'h01, 1'b0, 16'h1234);
    busy_len(w);
    width_ok(w, DCC_CALC_CYC + DCC_TAIL_CYC);
    check("codes", dac_codes_r, exp_c);
    dcc_host_model_inst.pulse_load();
    cyc(4);
    exp_c[15:0] = 16'h1234;
    check("codes", dac_codes_r, exp_c);
    $display("test single done");
  endtask : t_single
  task automatic t_all_busy();
    write(DCC_TGT_IN_A, 8'hff, 1'b0, 16'h4000);
    fork
      busy_len(w);
      begin
        cyc(20);
        dcc_host_model_inst.pulse_load();
        cyc(4);
        check("codes", dac_codes_r, exp_c);
      end
    join
    width_ok(w, 8 * DCC_CALC_CYC + DCC_TAIL_CYC);
    cyc(4);
    exp_c = {8{16'h4000}};
    check("codes", dac_codes_r, exp_c);
    $display("test all busy done");
  endtask : t_all_busy
  task automatic t_side_b();
    write(DCC_TGT_IN_B, 8'h10, 1'b0, 16'h2000);
    busy_len(w);
    // gain and offset written as a pair, once both errors are known
    write(DCC_TGT_GAIN, 8'h10, 1'b1, 16'h7fff);
    busy_len(w);
    write(DCC_TGT_OFFS, 8'h10, 1'b1, 16'h8010);
    busy_len(w);
    write(DCC_TGT_ABSEL, 8'hf0, 1'b0, 16'h0001);
    busy_len(w);
    width_ok(w, DCC_AB_CYC);
    dcc_host_model_inst.set_other(1'b0);
    dcc_host_model_inst.pulse_load();
    cyc(6);
    check("codes", dac_codes_r, exp_c);
    dcc_host_model_inst.set_other(1'b1);
    cyc(4);
    // half gain on 0x2000 gives 0x1000, offset adds 0x10
    exp_c[79:64] = 16'h1010;
    check("codes", dac_codes_r, exp_c);
    $display("test side b done");
  endtask : t_side_b
  task automatic t_clear();
    write(DCC_TGT_IN_A, 8'h02, 1'b0, 16'h0777);
    busy_len(w);
    dcc_host_model_inst.set_clear(1'b0);
    cyc(3);
    check("ground", out_to_ground_r, 1'b1);
    dcc_host_model_inst.pulse_load();
    cyc(4);
    check("codes", dac_codes_r, exp_c);
    dcc_host_model_inst.set_clear(1'b1);
    cyc(3);
    check("ground", out_to_ground_r, 1'b0);
    check("codes", dac_codes_r, exp_c);
    $display("test clear done");
  endtask : t_clear
  task automatic t_held();
    dcc_host_model_inst.set_load(1'b0);
    write(DCC_TGT_IN_A, 8'h04, 1'b0, 16'h0555);
    busy_len(w);
    cyc(4);
    exp_c[31:16] = 16'h0777;
    exp_c[47:32] = 16'h0555;
    check("codes", dac_codes_r, exp_c);
    dcc_host_model_inst.set_load(1'b1);
    $display("test held load done");
  endtask : t_held
  task automatic t_dev_reset();
    int i;
    dcc_host_model_inst.set_reset(1'b0);
    cyc(20);
    check("codes", dac_codes_r, exp_c);
    check("sequence", seq_active_r, 1'b0);
    dcc_host_model_inst.set_reset(1'b1);
    for (i = 0; i < 5 && seq_active_r !== 1'b1; i++)
      cyc(1);
    if (i == 5)
      timeout();
    exp_c = {8{DCC_DAC_DEF}};
    check("codes", dac_codes_r, exp_c);
    // no writes until the sequence is over
    for (i = 0; i < 200 && seq_active_r === 1'b1; i++)
      cyc(1);
    if (i == 200)
      timeout();
    check("sequence length", i >= 49 && i <= 51, 1'b1);
    dcc_host_model_inst.pulse_load();
    cyc(4);
    check("codes", dac_codes_r, exp_c);
    $display("test device reset done");
  endtask : t_dev_reset
  initial
  begin
    reset_n <= 1'b0;
    wr_en <= 1'b0;
    wr_target <= 3'h0;
    wr_chan_mask <= 8'h00;
    wr_ab <= 1'b0;
    wr_data <= 16'h0000;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(5);
    t_defaults();
    t_single();
    t_all_busy();
    t_side_b();
    t_clear();
    t_held();
    t_dev_reset();
    give_verdict();
  end
endmodule : test_dac_update_reset_clear_control
`default_nettype wire
